// ---- inc/phase_acc_osc_pkg.sv ----
// Shared constants and types of the phase accumulator oscillator
package phase_acc_osc_pkg;

    // Datapath widths
    localparam int ACC_W    = 20;                      // Accumulator and increment width
    localparam int BYTE_W   = 8;                       // Register byte width
    localparam int UPPER_W  = ACC_W - 2 * BYTE_W;      // Bits held by the upper byte
    localparam int PWS_W    = 3;                       // Pulse width select width
    localparam int PCNT_W   = 7;                       // Pulse counter width, up to 127

    // Byte field positions inside the 20-bit words
    localparam int LOW_LSB   = 0;                      // Low byte starts at bit 0
    localparam int HIGH_LSB  = 8;                      // High byte starts at bit 8
    localparam int UPPER_LSB = 16;                     // Upper byte starts at bit 16

    // Reset values
    localparam logic [ACC_W-1:0]  WORD_RST = 20'h00000;  // Words clear to zero
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;      // Bytes clear to zero
    localparam logic [PCNT_W-1:0] PCNT_RST = 7'h00;      // Pulse counter clear

    // Increment load delay in input clock edges after a low byte write
    localparam logic [1:0] LOAD_EDGES = 2'h2;
    localparam logic [1:0] LOAD_IDLE  = 2'h0;

    // Register index of each byte register
    typedef enum logic [2:0] {
        SEL_ACCUM_LOW   = 3'h0,
        SEL_ACCUM_HIGH  = 3'h1,
        SEL_ACCUM_UPPER = 3'h2,
        SEL_INCR_LOW    = 3'h3,
        SEL_INCR_HIGH   = 3'h4,
        SEL_INCR_UPPER  = 3'h5
    } reg_sel_t;

    // Clock source encoding
    typedef enum logic [1:0] {
        SRC_INTERNAL_HF = 2'h0,
        SRC_SYS_OSC     = 2'h1,
        SRC_LOGIC_CELL  = 2'h2,
        SRC_RESERVED    = 2'h3
    } clk_src_t;

    // Control and configuration bits
    typedef struct packed {
        logic                 osc_enable;           // Block runs when set
        logic                 output_mode_sel;      // 1 pulse frequency, 0 fixed duty
        logic                 output_invert;        // Inverts the final output
        logic [PWS_W-1:0]     pulse_width_sel;      // Pulse width is 2**value
        clk_src_t             osc_clock_source_sel; // Input clock choice
    } osc_cfg_t;

    // Byte register write request
    typedef struct packed {
        logic              wr_en;                   // Write strobe, one cycle
        reg_sel_t          sel;                     // Target register
        logic [BYTE_W-1:0] data;                    // Byte written
    } reg_wr_t;

endpackage : phase_acc_osc_pkg

// ---- rtl/clk_src_tick.sv ----
// Input clock selection turned into a one-cycle tick on each rising edge
`timescale 1ns/100ps
module clk_src_tick
    import phase_acc_osc_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     srst_i,
    // Source selection and candidate clocks
    input  wire clk_src_t sel_i,
    input  wire logic     internal_hf_osc_i,
    input  wire logic     logic_cell_out_i,
    // Tick out
    output logic          tick_o
);

    logic hf_prev_reg;   // Last sample of the internal oscillator
    logic hf_prev_next;
    logic lc_prev_reg;   // Last sample of the logic cell output
    logic lc_prev_next;

    // Next values of the history samples
    always_comb begin
        hf_prev_next = internal_hf_osc_i;
        lc_prev_next = logic_cell_out_i;
    end

    // History registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hf_prev_reg <= 1'b0;
            lc_prev_reg <= 1'b0;
        end else begin
            hf_prev_reg <= hf_prev_next;
            lc_prev_reg <= lc_prev_next;
        end
    end

    // Rising edge of the chosen source; system clock ticks every cycle
    always_comb begin
        case (sel_i)
            SRC_INTERNAL_HF: tick_o = internal_hf_osc_i & ~hf_prev_reg;
            SRC_SYS_OSC:     tick_o = 1'b1;
            SRC_LOGIC_CELL:  tick_o = logic_cell_out_i & ~lc_prev_reg;
            default:         tick_o = 1'b0;                              // Reserved code
        endcase
    end

endmodule : clk_src_tick

// ---- rtl/phase_acc_osc.sv ----
// Numerically controlled oscillator: accumulator, buffered increment and output shaper
// What this block does
// - Holds a readable, writable 20-bit accumulator
// - Each input edge adds buffered increment
// - Addition carry is the raw output
// - Two-bit field selects the input clock
// - Accumulator reached through low, high, upper bytes
// - Increment stored in low, high, upper bytes
// - Low write loads buffer on second edge
// - Disabled: increment writes load buffer immediately
// - Adder uses hidden double-buffered increment copy
// - Adder runs on selected input clock
// - Each carry raises an interrupt event
// - Carry shaped by toggle or pulse stretch
// - Mode bit: toggle, or pulse after carry
// - Pulse lasts 2**field input clock periods
// - Source codes: internal, system, logic cell, reserved
// - Invert bit flips output; status shows it
`timescale 1ns/100ps
module phase_acc_osc
    import phase_acc_osc_pkg::*;
(
    // Clock and reset
    input  wire logic              SYS_CLK_I,
    input  wire logic              SRST_I,
    // Configuration
    input  wire osc_cfg_t          CFG_I,
    // Byte register access
    input  wire reg_wr_t           REG_WR_I,
    input  wire reg_sel_t          RD_SEL_I,
    output logic [BYTE_W-1:0]      RD_DATA_O,
    // Candidate input clocks
    input  wire logic              INTERNAL_HF_OSC_I,
    input  wire logic              LOGIC_CELL_OUT_I,
    // Results
    output logic                   ACCUM_CARRY_O,
    output logic                   CARRY_EVENT_O,
    output logic                   OSC_OUT_O,
    output logic                   OUTPUT_STATUS_O
);

    // Pulse counter reload: width 2**sel periods, counted down to zero
    function automatic logic [PCNT_W-1:0] pulse_reload(input logic [PWS_W-1:0] sel);
        logic [PCNT_W:0] width;
        width = {{PCNT_W{1'b0}}, 1'b1} << sel;
        return width[PCNT_W-1:0] - {{(PCNT_W-1){1'b0}}, 1'b1};
    endfunction : pulse_reload

    // Merge one byte into a 20-bit word
    function automatic logic [ACC_W-1:0] put_byte(input logic [ACC_W-1:0] word,
                                                  input logic [1:0] idx,
                                                  input logic [BYTE_W-1:0] data);
        logic [ACC_W-1:0] res;
        res = word;
        case (idx)
            2'h0:    res[LOW_LSB +: BYTE_W]    = data;
            2'h1:    res[HIGH_LSB +: BYTE_W]   = data;
            default: res[UPPER_LSB +: UPPER_W] = data[UPPER_W-1:0];
        endcase
        return res;
    endfunction : put_byte

    // Read one byte from a 20-bit word, unused upper bits read as zero
    function automatic logic [BYTE_W-1:0] get_byte(input logic [ACC_W-1:0] word,
                                                   input logic [1:0] idx);
        logic [BYTE_W-1:0] res;
        res = BYTE_RST;
        case (idx)
            2'h0:    res = word[LOW_LSB +: BYTE_W];
            2'h1:    res = word[HIGH_LSB +: BYTE_W];
            default: res[UPPER_W-1:0] = word[UPPER_LSB +: UPPER_W];
        endcase
        return res;
    endfunction : get_byte

    logic               tick;           // One cycle per selected input clock edge
    logic [ACC_W-1:0]   acc_reg;        // Accumulator
    logic [ACC_W-1:0]   acc_next;
    logic [ACC_W-1:0]   incr_reg;       // Software visible increment
    logic [ACC_W-1:0]   incr_next;
    logic [ACC_W-1:0]   incr_buf_reg;   // Hidden copy used by the adder
    logic [ACC_W-1:0]   incr_buf_next;
    logic [1:0]         load_cnt_reg;   // Edges left before buffer load
    logic [1:0]         load_cnt_next;
    logic               carry_reg;      // Carry of the latest addition
    logic               carry_next;
    logic               event_reg;      // One-cycle carry event
    logic               event_next;
    logic               state_reg;      // Shaped output before inversion
    logic               state_next;
    logic [PCNT_W-1:0]  pcnt_reg;       // Pulse periods remaining
    logic [PCNT_W-1:0]  pcnt_next;
    logic               out_reg;        // Final output
    logic               out_next;
    logic [BYTE_W-1:0]  rd_reg;         // Read data
    logic [BYTE_W-1:0]  rd_next;
    logic [ACC_W:0]     sum;            // Adder result with carry
    logic               wr_acc;         // Write to an accumulator byte
    logic               wr_incr;        // Write to an increment byte
    logic [1:0]         wr_idx;         // Byte index of the write
    logic [1:0]         rd_idx;         // Byte index of the read

    // Edge detector on the chosen input clock
    clk_src_tick u_tick (
        .clk_i             (SYS_CLK_I),
        .srst_i            (SRST_I),
        .sel_i             (CFG_I.osc_clock_source_sel),
        .internal_hf_osc_i (INTERNAL_HF_OSC_I),
        .logic_cell_out_i  (LOGIC_CELL_OUT_I),
        .tick_o            (tick)
    );

    // Decode write target
    always_comb begin
        wr_acc  = REG_WR_I.wr_en && (REG_WR_I.sel <= SEL_ACCUM_UPPER);
        wr_incr = REG_WR_I.wr_en && (REG_WR_I.sel >= SEL_INCR_LOW)
                                 && (REG_WR_I.sel <= SEL_INCR_UPPER);
        wr_idx  = wr_acc ? REG_WR_I.sel[1:0] : 2'(REG_WR_I.sel - SEL_INCR_LOW);
        rd_idx  = (RD_SEL_I <= SEL_ACCUM_UPPER) ? RD_SEL_I[1:0]
                                                : 2'(RD_SEL_I - SEL_INCR_LOW);
    end

    // Increment registers and the hidden buffer
    always_comb begin
        incr_next     = incr_reg;
        incr_buf_next = incr_buf_reg;
        load_cnt_next = load_cnt_reg;
        if (wr_incr) begin
            incr_next = put_byte(incr_reg, wr_idx, REG_WR_I.data);
        end
        if (!CFG_I.osc_enable) begin
            load_cnt_next = LOAD_IDLE;
            if (wr_incr) begin
                incr_buf_next = incr_next;
            end
        end else begin
            // Count input edges towards the load; a fresh low write restarts it
            if (tick && (load_cnt_reg != LOAD_IDLE)) begin
                load_cnt_next = load_cnt_reg - 2'h1;
                if (load_cnt_reg == 2'h1) begin
                    incr_buf_next = incr_reg;
                end
            end
            if (wr_incr && (REG_WR_I.sel == SEL_INCR_LOW)) begin
                load_cnt_next = LOAD_EDGES;
            end
        end
    end

    // Adder and accumulator, advanced only on input clock edges
    always_comb begin
        sum        = {1'b0, acc_reg} + {1'b0, incr_buf_reg};
        acc_next   = acc_reg;
        carry_next = carry_reg;
        event_next = 1'b0;
        if (!CFG_I.osc_enable) begin
            carry_next = 1'b0;
        end else if (tick) begin
            acc_next   = sum[ACC_W-1:0];
            carry_next = sum[ACC_W];
            event_next = sum[ACC_W];
        end
        if (wr_acc) begin
            acc_next = put_byte(acc_reg, wr_idx, REG_WR_I.data);
        end
    end

    // Output shaper: toggle or stretched pulse, then polarity
    always_comb begin
        state_next = state_reg;
        pcnt_next  = pcnt_reg;
        if (!CFG_I.osc_enable) begin
            state_next = 1'b0;
            pcnt_next  = PCNT_RST;
        end else if (tick) begin
            if (!CFG_I.output_mode_sel) begin
                // Fixed duty: toggle on the edge that carries
                if (sum[ACC_W]) begin
                    state_next = ~state_reg;
                end
            end else if (carry_reg) begin
                // Pulse starts on the edge after the carry; a new carry restarts it
                state_next = 1'b1;
                pcnt_next  = pulse_reload(CFG_I.pulse_width_sel);
            end else if (state_reg) begin
                if (pcnt_reg == PCNT_RST) begin
                    state_next = 1'b0;
                end else begin
                    pcnt_next = pcnt_reg - 7'h01;
                end
            end
        end
        out_next = state_next ^ CFG_I.output_invert;
    end

    // Read data path
    always_comb begin
        if (RD_SEL_I <= SEL_ACCUM_UPPER) begin
            rd_next = get_byte(acc_reg, rd_idx);
        end else if (RD_SEL_I <= SEL_INCR_UPPER) begin
            rd_next = get_byte(incr_reg, rd_idx);
        end else begin
            rd_next = BYTE_RST;                                             // Unused index
        end
    end

    // All state registers, cleared on reset
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            acc_reg      <= WORD_RST;
            incr_reg     <= WORD_RST;
            incr_buf_reg <= WORD_RST;
            load_cnt_reg <= LOAD_IDLE;
            carry_reg    <= 1'b0;
            event_reg    <= 1'b0;
            state_reg    <= 1'b0;
            pcnt_reg     <= PCNT_RST;
            out_reg      <= 1'b0;
            rd_reg       <= BYTE_RST;
        end else begin
            acc_reg      <= acc_next;
            incr_reg     <= incr_next;
            incr_buf_reg <= incr_buf_next;
            load_cnt_reg <= load_cnt_next;
            carry_reg    <= carry_next;
            event_reg    <= event_next;
            state_reg    <= state_next;
            pcnt_reg     <= pcnt_next;
            out_reg      <= out_next;
            rd_reg       <= rd_next;
        end
    end

    // Outputs
    assign ACCUM_CARRY_O   = carry_reg;
    assign CARRY_EVENT_O   = event_reg;
    assign OSC_OUT_O       = out_reg;
    assign OUTPUT_STATUS_O = out_reg;
    assign RD_DATA_O       = rd_reg;

endmodule : phase_acc_osc

// ---- tb/phase_acc_osc_monitor.sv ----
// Port-level checker of the phase accumulator oscillator, bound to the top
`timescale 1ns/100ps
module phase_acc_osc_monitor
    import phase_acc_osc_pkg::*;
(
    // Clock and reset
    input wire logic              SYS_CLK_I,
    input wire logic              SRST_I,
    // Watched ports
    input wire osc_cfg_t          CFG_I,
    input wire reg_sel_t          RD_SEL_I,
    input wire logic [BYTE_W-1:0] RD_DATA_O,
    input wire logic              ACCUM_CARRY_O,
    input wire logic              CARRY_EVENT_O,
    input wire logic              OSC_OUT_O,
    input wire logic              OUTPUT_STATUS_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);

    // A carry seen in pulse mode with the system clock as source
    sequence s_pulse_go;
        CARRY_EVENT_O && CFG_I.osc_enable && CFG_I.output_mode_sel
            && (CFG_I.osc_clock_source_sel == SRC_SYS_OSC);
    endsequence
    // No new carry and settings unchanged
    sequence s_calm;
        !CARRY_EVENT_O && $stable(CFG_I);
    endsequence

    property p_status; OSC_OUT_O == OUTPUT_STATUS_O; endproperty
    property p_reset_clear;
        $past(SRST_I) |-> (RD_DATA_O == 8'h00) && !ACCUM_CARRY_O && !CARRY_EVENT_O && !OSC_OUT_O;
    endproperty
    property p_idle_event;
        !$past(CFG_I.osc_enable) |-> !CARRY_EVENT_O && !ACCUM_CARRY_O;
    endproperty
    property p_idle_level;
        (!CFG_I.osc_enable && $stable(CFG_I.output_invert)) [*3]
            |-> OSC_OUT_O == CFG_I.output_invert;
    endproperty
    property p_event_carry; CARRY_EVENT_O |-> ACCUM_CARRY_O; endproperty
    property p_fixed_toggle;
        !$past(SRST_I) && $past(CFG_I.osc_enable) && !$past(CFG_I.output_mode_sel)
            && ($past(CFG_I.output_invert) == $past(CFG_I.output_invert, 2))
            |-> (OSC_OUT_O != $past(OSC_OUT_O)) == CARRY_EVENT_O;
    endproperty
    property p_pulse_on;
        s_pulse_go ##1 $stable(CFG_I) |-> OSC_OUT_O != CFG_I.output_invert;
    endproperty
    property p_pulse_one;
        s_pulse_go ##0 (CFG_I.pulse_width_sel == 3'h0) ##1 s_calm ##1 $stable(CFG_I)
            |-> OSC_OUT_O == CFG_I.output_invert;
    endproperty
    property p_upper_mask;
        $past(RD_SEL_I) inside {SEL_ACCUM_UPPER, SEL_INCR_UPPER} |-> RD_DATA_O[7:4] == 4'h0;
    endproperty
    property p_unmapped;
        $past(RD_SEL_I) > SEL_INCR_UPPER |-> RD_DATA_O == 8'h00;
    endproperty

    a_status:       assert property (p_status) else $error("status differs from output");
    a_reset_clear:  assert property (p_reset_clear) else $error("outputs not clear after reset");
    a_idle_event:   assert property (p_idle_event) else $error("carry while disabled");
    a_idle_level:   assert property (p_idle_level) else $error("idle output level wrong");
    a_event_carry:  assert property (p_event_carry) else $error("event without carry");
    a_fixed_toggle: assert property (p_fixed_toggle) else $error("toggle not tied to carry");
    a_pulse_on:     assert property (p_pulse_on) else $error("pulse did not start");
    a_pulse_one:    assert property (p_pulse_one) else $error("one-period pulse too long");
    a_upper_mask:   assert property (p_upper_mask) else $error("upper byte high bits set");
    a_unmapped:     assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : phase_acc_osc_monitor

bind phase_acc_osc phase_acc_osc_monitor i_mon (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I),
    .CFG_I(CFG_I), .RD_SEL_I(RD_SEL_I), .RD_DATA_O(RD_DATA_O), .ACCUM_CARRY_O(ACCUM_CARRY_O),
    .CARRY_EVENT_O(CARRY_EVENT_O), .OSC_OUT_O(OSC_OUT_O), .OUTPUT_STATUS_O(OUTPUT_STATUS_O));

// ---- tb/phase_acc_osc_bench.sv ----
// Self-checking bench of the phase accumulator oscillator
`timescale 1ns/100ps
module phase_acc_osc_bench
    import phase_acc_osc_pkg::*;
;
    // Stimulus and observed signals
    logic              sys_clk  = 1'b0;
    logic              srst     = 1'b1;
    osc_cfg_t          cfg      = '0;
    reg_wr_t           wr       = '0;
    reg_sel_t          rd_sel   = SEL_ACCUM_LOW;
    logic              hf_osc   = 1'b0;
    logic              lc_out   = 1'b0;
    logic [BYTE_W-1:0] rd_data;
    logic              carry;
    logic              carry_ev;
    logic              osc_out;
    logic              status;
    // Counters of checks and of output activity
    int                mismatches = 0;
    int                compares   = 0;
    int                ev_cnt, hi_cnt, tg_cnt;

    phase_acc_osc i_dut (.SYS_CLK_I(sys_clk), .SRST_I(srst), .CFG_I(cfg), .REG_WR_I(wr),
        .RD_SEL_I(rd_sel), .RD_DATA_O(rd_data), .INTERNAL_HF_OSC_I(hf_osc),
        .LOGIC_CELL_OUT_I(lc_out), .ACCUM_CARRY_O(carry), .CARRY_EVENT_O(carry_ev),
        .OSC_OUT_O(osc_out), .OUTPUT_STATUS_O(status));

    // 200 MHz clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Verdict and end of run
    task automatic results();
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // Compare one byte, report a difference
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One clock, inputs change 1 ns after the edge; counts output activity
    task automatic tick();
        logic prev;
        prev = osc_out;
        @(posedge sys_clk);
        #1;
        ev_cnt += (carry_ev === 1'b1);
        hi_cnt += (osc_out === 1'b1);
        tg_cnt += (osc_out !== prev);
    endtask : tick
    task automatic run(input int n);
        repeat (n) tick();
    endtask : run
    // Single-cycle register write, then one idle cycle before the next
    task automatic wr_reg(input reg_sel_t sel, input logic [7:0] d);
        wr = '{1'b1, sel, d};
        tick();
        wr.wr_en = 1'b0;
        tick();
    endtask : wr_reg
    task automatic rd_chk(input reg_sel_t sel, input logic [7:0] exp);
        rd_sel = sel;
        tick();
        check(rd_data, exp);
    endtask : rd_chk
    task automatic set_acc(input logic [19:0] a);
        wr_reg(SEL_ACCUM_LOW, a[7:0]);
        wr_reg(SEL_ACCUM_HIGH, a[15:8]);
        wr_reg(SEL_ACCUM_UPPER, {4'h0, a[19:16]});
    endtask : set_acc
    // Upper and high first, low last
    task automatic set_inc(input logic [19:0] i);
        wr_reg(SEL_INCR_UPPER, {4'h0, i[19:16]});
        wr_reg(SEL_INCR_HIGH, i[15:8]);
        wr_reg(SEL_INCR_LOW, i[7:0]);
    endtask : set_inc

    // Everything reads zero after reset; writes to unmapped places are lost
    task automatic t_reset();
        wr_reg(reg_sel_t'(3'h6), 8'hff);
        for (int i = 0; i < 8; i++) rd_chk(reg_sel_t'(3'(i)), 8'h00);
    endtask : t_reset

    // Byte write and read back, upper nibble dropped
    task automatic t_bytes();
        logic [7:0] wv [6] = '{8'h12, 8'h34, 8'hff, 8'ha5, 8'h5a, 8'hf3};
        logic [7:0] rv [6] = '{8'h12, 8'h34, 8'h0f, 8'ha5, 8'h5a, 8'h03};
        for (int i = 0; i < 6; i++) wr_reg(reg_sel_t'(3'(i)), wv[i]);
        for (int i = 0; i < 6; i++) rd_chk(reg_sel_t'(3'(i)), rv[i]);
    endtask : t_bytes

    // Twenty additions of a value loaded while disabled
    task automatic t_adder();
        cfg.osc_clock_source_sel = SRC_SYS_OSC;
        set_acc(20'h00000);
        set_inc(20'h33333);
        ev_cnt = 0;
        cfg.osc_enable = 1'b1;
        run(20);
        cfg.osc_enable = 1'b0;
        run(2);
        check(8'(ev_cnt), 8'h03);
        rd_chk(SEL_ACCUM_LOW, 8'hfc);
        rd_chk(SEL_ACCUM_HIGH, 8'hff);
        rd_chk(SEL_ACCUM_UPPER, 8'h0f);
    endtask : t_adder

    // Low write while running takes effect on the second input edge
    task automatic t_delayed();
        set_acc(20'h00000);
        set_inc(20'h00000);
        cfg.osc_enable = 1'b1;
        wr_reg(SEL_INCR_LOW, 8'h01);
        run(9);
        cfg.osc_enable = 1'b0;
        rd_chk(SEL_ACCUM_LOW, 8'h08);
    endtask : t_delayed

    // Three rising edges on one source, five on the other, none on reserved
    task automatic t_sources();
        clk_src_t   srcs [3] = '{SRC_INTERNAL_HF, SRC_LOGIC_CELL, SRC_RESERVED};
        logic [7:0] exp  [3] = '{8'h03, 8'h05, 8'h00};
        for (int k = 0; k < 3; k++) begin
            set_acc(20'h00000);
            cfg.osc_clock_source_sel = srcs[k];
            cfg.osc_enable = 1'b1;
            for (int i = 0; i < 10; i++) begin
                hf_osc = i[0] && (i < 6);
                lc_out = i[0];
                tick();
            end
            hf_osc = 1'b0;
            lc_out = 1'b0;
            run(3);
            cfg.osc_enable = 1'b0;
            rd_chk(SEL_ACCUM_LOW, exp[k]);
        end
    endtask : t_sources

    // Toggle mode, pulse widths, over-long pulse and inverted idle level
    task automatic t_shape();
        cfg.osc_clock_source_sel = SRC_SYS_OSC;
        set_inc(20'h80000);
        set_acc(20'h00000);
        tg_cnt = 0;
        cfg.osc_enable = 1'b1;
        run(40);
        check({7'h00, carry}, 8'h01);
        cfg.osc_enable = 1'b0;
        check(8'(tg_cnt), 8'h14);
        set_inc(20'h08000);
        cfg.output_mode_sel = 1'b1;
        for (int p = 0; p < 5; p++) begin
            set_acc(20'h00000);
            cfg.pulse_width_sel = 3'(p);
            hi_cnt = 0;
            cfg.osc_enable = 1'b1;
            run(60);
            cfg.osc_enable = 1'b0;
            check(8'(hi_cnt), 8'(1 << p));
        end
        set_inc(20'h80000);
        set_acc(20'h00000);
        cfg.pulse_width_sel = 3'h7;
        cfg.osc_enable = 1'b1;
        run(10);
        hi_cnt = 0;
        run(20);
        check(8'(hi_cnt), 8'h14);
        cfg.osc_enable = 1'b0;
        cfg.output_invert = 1'b1;
        run(3);
        check({7'h00, osc_out}, 8'h01);
        check({7'h00, status}, 8'h01);
    endtask : t_shape

    // Reset for eight clocks, then the scenarios
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_bytes();
        t_adder();
        t_delayed();
        t_sources();
        t_shape();
        results();
    end

    // Watchdog well beyond the expected run time
    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule : phase_acc_osc_bench
